// ### src/wfp_defines.vh
// Constants for the waveform file parser.
// Assumes inclusion by bare name from design files.
`ifndef WFP_DEFINES_VH
`define WFP_DEFINES_VH
`define WFP_CSUM_SEED 32'hA50F74FF
`define WFP_CH_LBRACE 8'h7B
`define WFP_CH_RBRACE 8'h7D
`define WFP_CH_COLON 8'h3A
`define WFP_CH_DASH 8'h2D
`define WFP_CH_HASH 8'h23
`define WFP_CH_COMMA 8'h2C
`define WFP_CH_SPACE 8'h20
`define WFP_CH_ZERO 8'h30
`define WFP_CH_NINE 8'h39
`define WFP_CH_DOT 8'h2E
`define WFP_CH_E 8'h65
`define WFP_CH_BIG_E 8'h45
`define WFP_CH_MINUS 8'h2D
`define WFP_MARK_LEN 32'h00000001
`define WFP_PAIR_BYTES 4
`define WFP_SIG_LEN 6
// Signature value is arbitrary
`define WFP_SIG 48'h4142432D5746
`define WFP_NAME_TYPE 64'h0000000054595045
`define WFP_NAME_CLOCK 64'h000000434C4F434B
`define WFP_NAME_SAMPLES 64'h0053414D504C4553
`define WFP_NAME_WAVE 64'h57415645464F524D
// Last eight name characters of the level tag
`define WFP_NAME_LEVEL 64'h4C204F4646534554
`define WFP_NAME_ZERO 64'h0000000000000000
`endif

// ### src/wfp_ascii_num.v
// Decimal ASCII accumulator with mantissa, exponent and sign tracking.
// Assumes one character per enabled cycle on the system clock.
`default_nettype none
`include "wfp_defines.vh"
module wfp_ascii_num (
	input wire sys_clk,
	input wire rstSync_b,
	input wire clkEn,
	input wire clear,
	input wire charValid,
	input wire [7:0] charIn,
	output reg [31:0] value_q,
	output reg numeric_q,
	output reg negative_q
);
	reg inExp_q;
	reg [7:0] expVal_q;
	reg [31:0] mant_q;
	reg [31:0] mantNext;
	reg [7:0] expNext;
	wire isDigit = (charIn >= `WFP_CH_ZERO) && (charIn <= `WFP_CH_NINE);
	function [31:0] times10;
		input [31:0] v;
		times10 = (v << 3) + (v << 1);
	endfunction
	integer k;
	reg [31:0] scaled;
	// Next mantissa and exponent, so value is current right after each digit
	always @* begin
		mantNext = mant_q;
		expNext = expVal_q;
		scaled = 32'h00000000;
		if (clear) begin
			mantNext = 32'h00000000;
			expNext = 8'h00;
		end else if (charValid && isDigit && !inExp_q) begin
			mantNext = times10(mant_q) + {24'h000000, charIn - `WFP_CH_ZERO};
		end else if (charValid && isDigit) begin
			expNext = (expVal_q << 3) + (expVal_q << 1) + (charIn - `WFP_CH_ZERO);
		end
		scaled = mantNext;
		for (k = 0; k < 10; k = k + 1) begin
			if (k < expNext)
				scaled = times10(scaled);
		end
	end
	always @(posedge sys_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			value_q <= 32'h00000000;
			mant_q <= 32'h00000000;
			expVal_q <= 8'h00;
			inExp_q <= 1'b0;
			numeric_q <= 1'b0;
			negative_q <= 1'b0;
		end else if (clkEn) begin
			mant_q <= mantNext;
			expVal_q <= expNext;
			value_q <= scaled;
			if (clear) begin
				inExp_q <= 1'b0;
				numeric_q <= 1'b0;
				negative_q <= 1'b0;
			end else if (charValid) begin
				if (isDigit && !inExp_q) begin
					numeric_q <= 1'b1;
				end else if (charIn == `WFP_CH_E || charIn == `WFP_CH_BIG_E) begin
					inExp_q <= 1'b1;
				end else if (charIn == `WFP_CH_MINUS && !numeric_q) begin
					negative_q <= 1'b1;
				end
			end
		end
	end
endmodule // wfp_ascii_num
`default_nettype wire

// ### src/wfp_waveform_file_parser.v
// Tag parser for waveform files: signature, checksum, clock, samples, I/Q unpacking.
// Assumes bytes from the host on the system clock, and a converter accepting pairs.
//
// Contract
// - File valid only if the type field holds the self-contained signature.
// - Checksum check skipped when its field is zero or non-numeric.
// - Checksum is seed XORed with every 32-bit data word.
// - Checksummed bytes run from after the marker to before the brace, multiple of four.
// - Computed checksum compared against decimal value in type tag.
// - Clock tag mandatory; rate reported after load; override input replaces it, except in the cycle a clock tag closes, where the tag value wins.
// - Level tag holds mean power then crest backoff; the first never negative.
// - Negative crest backoff flags possible clipping, positive means headroom.
// - Optional samples tag gives pair count in decimal ASCII.
// - Data length equals one plus four bytes per pair.
// - Samples are 16-bit, I then Q, least significant byte first.
// - Samples within full scale pass unchanged to the converter.
// - Tags are braced upper-case name, optional dash and length, colon, optional space, data.
// - Unknown tags ignored without error; their data is discarded, not kept for reading back.
`default_nettype none
`include "wfp_defines.vh"
module wfp_waveform_file_parser (
	input wire sys_clk,
	input wire rst_b,
	input wire clkEn,
	input wire byteValid,
	input wire [7:0] byteData,
	input wire fileStart,
	input wire sampleTick,
	input wire clockOverride,
	input wire [31:0] clockOverrideVal,
	output reg [31:0] sampleClockHz_q,
	output reg [31:0] sampleCount_q,
	output reg fileValid_q,
	output reg fileError_q,
	output reg clipWarn_q,
	output reg iqValid_q,
	output reg [15:0] iSample_q,
	output reg [15:0] qSample_q,
	output reg [15:0] iqWordAddr_q,
	output reg iqWrite_q,
	output reg [31:0] iqWriteData_q,
	output reg playDone_q
);
	localparam S_IDLE = 9'h001;
	localparam S_NAME = 9'h002;
	localparam S_LEN = 9'h004;
	localparam S_DATA = 9'h008;
	localparam S_MARK = 9'h010;
	localparam S_BIN = 9'h020;
	localparam S_END = 9'h040;
	localparam S_PLAY = 9'h080;
	localparam S_DONE = 9'h100;
	reg rstMeta_q, rstSync_q;
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end
	// ****************************************
	// Tag framing and field capture
	// ****************************************
	reg [8:0] state_q;
	reg [63:0] name_q;
	reg [31:0] lenField_q, binCount_q, csum_q, word_q;
	reg [1:0] byteIdx_q;
	reg [47:0] sig_q;
	reg inSig_q, afterComma_q, firstTag_q;
	reg seenType_q, seenClock_q, seenWave_q, sigOk_q;
	reg [31:0] csumRef_q;
	reg csumEn_q;
	reg levelSecond_q;
	reg [15:0] wrAddr_q, playAddr_q;
	reg [31:0] store [0:65535];
	reg [31:0] playWord;
	wire numClear = (state_q == S_NAME) || (byteValid && ((state_q == S_LEN && byteData == `WFP_CH_COLON) ||
		(state_q == S_DATA && byteData == `WFP_CH_COMMA)));
	wire numFeed = byteValid && ((state_q == S_LEN) || (state_q == S_DATA));
	wire [31:0] numVal;
	wire numIsNum, numNeg;
	wfp_ascii_num uNum (
		.sys_clk(sys_clk),
		.rstSync_b(rstSync_q),
		.clkEn(clkEn),
		.clear(numClear),
		.charValid(numFeed),
		.charIn(byteData),
		.value_q(numVal),
		.numeric_q(numIsNum),
		.negative_q(numNeg)
	);
	wire isType = (name_q == `WFP_NAME_TYPE);
	wire isClock = (name_q == `WFP_NAME_CLOCK);
	wire isSamples = (name_q == `WFP_NAME_SAMPLES);
	wire isWave = (name_q == `WFP_NAME_WAVE);
	wire isLevel = (name_q == `WFP_NAME_LEVEL);
	wire [31:0] wordNext = {byteData, word_q[31:8]};
	always @(posedge sys_clk) begin
		if (clkEn && iqWrite_q)
			store[iqWordAddr_q] <= iqWriteData_q;
	end
	always @* begin
		playWord = store[playAddr_q];
	end
	always @(posedge sys_clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			state_q <= S_IDLE;
			name_q <= `WFP_NAME_ZERO;
			lenField_q <= 32'h00000000;
			binCount_q <= 32'h00000000;
			csum_q <= `WFP_CSUM_SEED;
			word_q <= 32'h00000000;
			byteIdx_q <= 2'h0;
			sig_q <= 48'h000000000000;
			inSig_q <= 1'b0;
			afterComma_q <= 1'b0;
			firstTag_q <= 1'b1;
			seenType_q <= 1'b0;
			seenClock_q <= 1'b0;
			seenWave_q <= 1'b0;
			sigOk_q <= 1'b0;
			csumRef_q <= 32'h00000000;
			csumEn_q <= 1'b0;
			levelSecond_q <= 1'b0;
			wrAddr_q <= 16'h0000;
			playAddr_q <= 16'h0000;
			sampleClockHz_q <= 32'h00000000;
			sampleCount_q <= 32'h00000000;
			fileValid_q <= 1'b0;
			fileError_q <= 1'b0;
			clipWarn_q <= 1'b0;
			iqValid_q <= 1'b0;
			iSample_q <= 16'h0000;
			qSample_q <= 16'h0000;
			iqWordAddr_q <= 16'h0000;
			iqWrite_q <= 1'b0;
			iqWriteData_q <= 32'h00000000;
			playDone_q <= 1'b0;
		end else if (clkEn) begin
			iqWrite_q <= 1'b0;
			iqValid_q <= 1'b0;
			if (clockOverride)
				sampleClockHz_q <= clockOverrideVal;
			if (fileStart) begin
				state_q <= S_IDLE;
				firstTag_q <= 1'b1;
				seenType_q <= 1'b0;
				seenClock_q <= 1'b0;
				seenWave_q <= 1'b0;
				sigOk_q <= 1'b0;
				csumEn_q <= 1'b0;
				fileValid_q <= 1'b0;
				fileError_q <= 1'b0;
				clipWarn_q <= 1'b0;
				sampleCount_q <= 32'h00000000;
				wrAddr_q <= 16'h0000;
				playDone_q <= 1'b0;
			end else begin
				case (state_q)
				S_IDLE: begin
					if (byteValid && byteData == `WFP_CH_LBRACE) begin
						state_q <= S_NAME;
						name_q <= `WFP_NAME_ZERO;
					end
				end
				S_NAME: begin
					if (byteValid) begin
						if (byteData == `WFP_CH_COLON || byteData == `WFP_CH_DASH) begin
							if (firstTag_q && !isType)
								fileError_q <= 1'b1;
							firstTag_q <= 1'b0;
							state_q <= (byteData == `WFP_CH_DASH) ? S_LEN : S_DATA;
							inSig_q <= 1'b1;
							afterComma_q <= 1'b0;
							levelSecond_q <= 1'b0;
							sig_q <= 48'h000000000000;
						end else begin
							name_q <= {name_q[55:0], byteData};
						end
					end
				end
				S_LEN: begin
					if (byteValid && byteData == `WFP_CH_COLON) begin
						lenField_q <= numVal;
						state_q <= isWave ? S_MARK : S_DATA;
					end
				end
				S_MARK: begin
					if (byteValid && byteData == `WFP_CH_HASH) begin
						state_q <= S_BIN;
						binCount_q <= `WFP_MARK_LEN;
						csum_q <= `WFP_CSUM_SEED;
						byteIdx_q <= 2'h0;
					end
				end
				S_DATA: begin
					// Comment, date and unknown tags pass through uninterpreted
					if (byteValid && byteData == `WFP_CH_RBRACE) begin
						state_q <= S_IDLE;
						if (isType) begin
							seenType_q <= 1'b1;
							sigOk_q <= (sig_q == `WFP_SIG);
							if (afterComma_q) begin
								csumRef_q <= numVal;
								csumEn_q <= numIsNum && (numVal != 32'h00000000);
							end
						end
						if (isClock) begin
							sampleClockHz_q <= numVal;
							seenClock_q <= 1'b1;
						end
						if (isSamples)
							sampleCount_q <= numVal;
						if (isLevel && levelSecond_q && numNeg && numIsNum)
							clipWarn_q <= 1'b1;
					end else if (byteValid && byteData == `WFP_CH_COMMA) begin
						afterComma_q <= 1'b1;
						inSig_q <= 1'b0;
						levelSecond_q <= 1'b1;
					end else if (byteValid && inSig_q && byteData != `WFP_CH_SPACE) begin
						sig_q <= {sig_q[39:0], byteData};
					end
				end
				S_BIN: begin
					if (byteValid) begin
						if (binCount_q == lenField_q) begin
							state_q <= S_END;
							if (byteData != `WFP_CH_RBRACE || byteIdx_q != 2'h0)
								fileError_q <= 1'b1;
						end else begin
							binCount_q <= binCount_q + 32'h00000001;
							word_q <= wordNext;
							byteIdx_q <= byteIdx_q + 2'h1;
							if (byteIdx_q == 2'h3) begin
								csum_q <= csum_q ^ wordNext;
								iqWrite_q <= 1'b1;
								iqWriteData_q <= wordNext;
								iqWordAddr_q <= wrAddr_q;
								wrAddr_q <= wrAddr_q + 16'h0001;
							end
						end
					end
				end
				S_END: begin
					seenWave_q <= 1'b1;
					if (!seenType_q || !sigOk_q || !seenClock_q ||
						(csumEn_q && csum_q != csumRef_q) ||
						(sampleCount_q != 32'h00000000 && {sampleCount_q[29:0], 2'b00} +
						`WFP_MARK_LEN != lenField_q)) begin
						fileError_q <= 1'b1;
						state_q <= S_DONE;
					end else if (!fileError_q) begin
						fileValid_q <= 1'b1;
						if (sampleCount_q == 32'h00000000)
							sampleCount_q <= {16'h0000, wrAddr_q};
						playAddr_q <= 16'h0000;
						state_q <= S_PLAY;
					end else begin
						state_q <= S_DONE;
					end
				end
				S_PLAY: begin
					if (sampleTick) begin
						iSample_q <= playWord[15:0];
						qSample_q <= playWord[31:16];
						iqValid_q <= 1'b1;
						if (playAddr_q + 16'h0001 == wrAddr_q) begin
							playAddr_q <= 16'h0000;
							playDone_q <= 1'b1;
						end else begin
							playAddr_q <= playAddr_q + 16'h0001;
						end
					end
				end
				S_DONE: begin
					state_q <= S_DONE;
				end
				default: begin
					state_q <= S_IDLE;
				end
				endcase
			end
		end
	end
endmodule // wfp_waveform_file_parser
`default_nettype wire

// ### tb/wfp_waveform_file_parser_chk.sv
// Checker for the waveform file parser top ports.
// Assumes one clock domain and rst_b active low.
`default_nettype none
module wfp_parser_chk (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic byteValid,
	input wire logic [7:0] byteData,
	input wire logic fileStart,
	input wire logic sampleTick,
	input wire logic clockOverride,
	input wire logic [31:0] clockOverrideVal,
	input wire logic [31:0] sampleClockHz_q,
	input wire logic fileValid_q,
	input wire logic fileError_q,
	input wire logic iqValid_q,
	input wire logic iqWrite_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence tickTaken;
		clkEn && sampleTick && fileValid_q && !fileError_q;
	endsequence
	sequence braceTaken;
		clkEn && byteValid && byteData == 8'h7D;
	endsequence
	tick_gives_pair_a: assert property (tickTaken |=> iqValid_q) else $error("no pair after tick");
	pair_has_cause_a: assert property (iqValid_q |-> $past(sampleTick)) else $error("pair without tick");
	error_blocks_a: assert property (fileError_q |-> !iqValid_q) else $error("pair after error");
	status_exclusive_a: assert property (!(fileValid_q && fileError_q)) else $error("valid and error");
	error_sticky_a: assert property ($fell(fileError_q) |-> $past(fileStart)) else $error("error dropped");
	valid_after_brace_a: assert property ($rose(fileValid_q) |-> $past(byteValid && byteData == 8'h7D, 2))
		else $error("valid not after brace");
	word_write_pulse_a: assert property (iqWrite_q |=> !iqWrite_q ##1 !iqWrite_q) else $error("write too long");
	override_load_a: assert property (clkEn && clockOverride |=> sampleClockHz_q == $past(clockOverrideVal))
		else $error("override lost");
	cover property (braceTaken);
endmodule // wfp_parser_chk
bind wfp_waveform_file_parser wfp_parser_chk chk (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn),
	.byteValid(byteValid), .byteData(byteData), .fileStart(fileStart), .sampleTick(sampleTick),
	.clockOverride(clockOverride), .clockOverrideVal(clockOverrideVal), .sampleClockHz_q(sampleClockHz_q),
	.fileValid_q(fileValid_q), .fileError_q(fileError_q), .iqValid_q(iqValid_q), .iqWrite_q(iqWrite_q));
`default_nettype wire

// ### tb/wfp_host.sv
// Host model sending file bytes one per strobe.
// Assumes the bench calls its tasks after reset.
`default_nettype none
module wfp_host (
	input wire logic sys_clk,
	output var logic byteValid,
	output var logic [7:0] byteData
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		byteValid = 1'b0;
		byteData = 8'h00;
	end
	// Released data shows the inverse of the last byte
	task automatic sendByte(input logic [7:0] b);
		@(posedge sys_clk);
		byteValid <= 1'b1;
		byteData <= b;
		@(posedge sys_clk);
		byteValid <= 1'b0;
		byteData <= ~b;
	endtask
	task automatic sendStr(input string s);
		for (int k = 0; k < s.len(); k++) sendByte(s[k]);
	endtask
endmodule // wfp_host
`default_nettype wire

// ### tb/wfp_waveform_file_parser_tb.sv
// Testbench for the waveform file parser.
// Assumes the design header sits on the include path.
`default_nettype none
`include "wfp_defines.vh"
module wfp_waveform_file_parser_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] W0 = 32'h80017FFF;
	localparam logic [31:0] W1 = 32'h12340000;
	localparam logic [31:0] CSUM = 32'hA50F74FF ^ W0 ^ W1;
	logic sys_clk, rst_b, clkEn, fileStart, sampleTick, clockOverride, byteValid, iqValid_q, iqWrite_q;
	logic fileValid_q, fileError_q, clipWarn_q, playDone_q;
	logic [7:0] byteData;
	logic [15:0] iSample_q, qSample_q, iqWordAddr_q, lastAddr;
	logic [31:0] clockOverrideVal, sampleClockHz_q, sampleCount_q, iqWriteData_q;
	logic [31:0] wq[$];
	int bad_count = 0, compares = 0, cyc = 0;
	wfp_host host (.sys_clk(sys_clk), .byteValid(byteValid), .byteData(byteData));
	wfp_waveform_file_parser DUT (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .byteValid(byteValid),
		.byteData(byteData), .fileStart(fileStart), .sampleTick(sampleTick), .clockOverride(clockOverride),
		.clockOverrideVal(clockOverrideVal), .sampleClockHz_q(sampleClockHz_q), .sampleCount_q(sampleCount_q),
		.fileValid_q(fileValid_q), .fileError_q(fileError_q), .clipWarn_q(clipWarn_q), .iqValid_q(iqValid_q),
		.iSample_q(iSample_q), .qSample_q(qSample_q), .iqWordAddr_q(iqWordAddr_q), .iqWrite_q(iqWrite_q),
		.iqWriteData_q(iqWriteData_q), .playDone_q(playDone_q));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (iqWrite_q === 1'b1) begin
			wq.push_back(iqWriteData_q);
			lastAddr <= iqWordAddr_q;
		end
		cyc++;
		if (cyc == 8000) begin
			bad_count++;
			stop_test();
		end
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One-cycle strobe: 0 file start, 1 sample tick, 2 clock override
	task automatic pulse(input int sel);
		@(posedge sys_clk);
		if (sel == 0) fileStart <= 1'b1;
		else if (sel == 1) sampleTick <= 1'b1;
		else clockOverride <= 1'b1;
		@(posedge sys_clk);
		fileStart <= 1'b0;
		sampleTick <= 1'b0;
		clockOverride <= 1'b0;
	endtask
	// Sends one file and waits for the verdict
	task automatic sendFile(input string cs, input bit typeLate, input int len, input string crest);
		string t;
		t = "{TYPE: ";
		for (int k = 5; k >= 0; k--) t = {t, string'(8'(`WFP_SIG >> (8 * k)))};
		t = {t, ",", cs, "}"};
		wq.delete();
		pulse(0);
		if (!typeLate) host.sendStr(t);
		host.sendStr({"{CLOCK: 10}{COMMENT: a:b}{ODD: q}{SAMPLES: 2}{LEVEL OFFSET: 3.45,", crest, "}"});
		if (typeLate) host.sendStr(t);
		host.sendStr($sformatf("{WAVEFORM-%0d:#", len));
		for (int k = 0; k < 8; k++) host.sendByte(8'({W1, W0} >> (8 * k)));
		host.sendStr("}");
		for (int n = 0; n < 6 && fileValid_q !== 1'b1 && fileError_q !== 1'b1; n++) @(posedge sys_clk);
		#1;
	endtask
	// Plays one pair and compares it
	task automatic playPair(input logic [15:0] i, input logic [15:0] q);
		pulse(1);
		#1;
		check("iqValid", 32'h1, {31'h0, iqValid_q});
		check("iSample", {16'h0, i}, {16'h0, iSample_q});
		check("qSample", {16'h0, q}, {16'h0, qSample_q});
	endtask
	task automatic goodFile();
		sendFile($sformatf("%0d", CSUM), 1'b0, 9, "-2");
		check("fileValid", 32'h1, {31'h0, fileValid_q});
		check("fileError", 32'h0, {31'h0, fileError_q});
		check("clock", 32'd10, sampleClockHz_q);
		check("count", 32'd2, sampleCount_q);
		check("clip", 32'h1, {31'h0, clipWarn_q});
		check("words", 32'd2, wq.size());
		check("word0", W0, wq.size() > 0 ? wq[0] : 32'hX);
		check("word1", W1, wq.size() > 1 ? wq[1] : 32'hX);
		check("wordAddr", 32'h1, {16'h0, lastAddr});
		playPair(16'h7FFF, 16'h8001);
		playPair(16'h0000, 16'h1234);
		check("playDone", 32'h1, {31'h0, playDone_q});
		@(posedge sys_clk);
		clockOverrideVal <= 32'h00989680;
		pulse(2);
		#1;
		check("override", 32'h00989680, sampleClockHz_q);
		@(posedge sys_clk);
		clkEn <= 1'b0;
		clockOverrideVal <= 32'h00000005;
		pulse(2);
		pulse(1);
		#1;
		check("frozenClock", 32'h00989680, sampleClockHz_q);
		check("frozenTick", 32'h0, {31'h0, iqValid_q});
		@(posedge sys_clk);
		clkEn <= 1'b1;
	endtask
	task automatic otherFile(input string cs, input bit late, input int len, input bit expErr);
		sendFile(cs, late, len, "2");
		check("fileError", {31'h0, expErr}, {31'h0, fileError_q});
		check("fileValid", {31'h0, !expErr}, {31'h0, fileValid_q});
		check("clip", 32'h0, {31'h0, clipWarn_q});
		pulse(1);
		#1;
		check("blocked", {31'h0, !expErr}, {31'h0, iqValid_q});
	endtask
	task automatic stop_test();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		clkEn = 1'b1;
		fileStart = 1'b0;
		sampleTick = 1'b0;
		clockOverride = 1'b0;
		clockOverrideVal = 32'h0;
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		goodFile();
		otherFile($sformatf("%0d", CSUM + 32'd1), 1'b0, 9, 1'b1);
		otherFile("0", 1'b1, 9, 1'b1);
		otherFile("0", 1'b0, 5, 1'b1);
		otherFile("zz", 1'b0, 9, 1'b0);
		otherFile("0", 1'b0, 9, 1'b0);
		stop_test();
	end
endmodule // wfp_waveform_file_parser_tb
`default_nettype wire
